//--- design/cspc_socket_power_control_reg.sv
// Socket power control register with APB access and power switch decode.
// How it works
// R1 - Bit 7 gates all 16-bit card outputs.
// R2 - Supply-enable layout: bit 6 reads zero.
// R3 - Supply-enable layout: bit 5 enables auto switching.
// R4 - Bit 4 enables Vcc, level from system bit.
// R5 - Supply-enable layout: bits 3:2 read zero.
// R6 - Vpp field: 00 off, 10 12V, 01 Vcc.
// R7 - Vpp ignored while Vcc is not enabled.
// R8 - Vcc-field layout: bits 6:5 reserved, zero.
// R9 - Vcc field: 00/01 off, 10 5V, 11 3.3V.
// R10 - Vcc-field layout: bit 2 reserved, zero.
// R11 - Vpp field: 00/11 off, 10 12V.
// R12 - With events enabled only global reset clears the sticky bits.
// R13 - Power status reads one when supply on.
// R14 - Static input selects layout for decoding.
`timescale 1ns/1ps
`default_nettype none
`include "cspc_defines.svh"
module cspc_socket_power_control_reg
#(
  parameter int ADDR_W = 14
)
(
  // Clock, enable and resets.
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  clkEn,
  input  wire logic                  global_reset_in_n,
  input  wire logic                  bus_reset_in_n,
  input  wire logic                  pmeEnable,
  // Static layout choice.
  input  wire cspc_pkg::cspc_layout_t layoutSel,
  // Card detect pins, active low.
  input  wire logic                  cardDetect1_n,
  input  wire logic                  cardDetect2_n,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // Power switch and card side.
  output var  cspc_pkg::cspc_switch_t switchCmd,
  output var  logic                  card_output_gate,
  output var  logic                  socket_power_status
);

  // Elaboration check: twelve-bit word indices need fourteen byte-address bits.
  // A narrower bus could not tell the power register from its neighbours.
  if (ADDR_W < 14)
  begin : g_bad_width
    $error("ADDR_W must be at least 14");
  end

  // Filtered card detect levels, high while that contact is seated.
  logic cd1Seated;
  logic cd2Seated;

  // Card detect pins come from outside and pass the three-stage filter.
  // They are inverted in front of it so that its reset level means no card;
  // otherwise a card would seem seated for a few cycles after every reset.
  cspc_sync u_sync_cd1
  (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .asyncIn (~cardDetect1_n),
    .syncOut (cd1Seated)
  );
  cspc_sync u_sync_cd2
  (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .asyncIn (~cardDetect2_n),
    .syncOut (cd2Seated)
  );

  // Synchronised reset pins; resets act as clocked clears so sticky bits survive.
  // The filter delays a reset by three to four cycles, so pins must stay low longer.
  logic grstSync;
  logic prstSync;
  cspc_sync u_sync_global_reset_in
  (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .asyncIn (~global_reset_in_n),
    .syncOut (grstSync)
  );
  cspc_sync u_sync_bus_reset_in
  (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .asyncIn (~bus_reset_in_n),
    .syncOut (prstSync)
  );

  // Register state.
  // Every register here sits under the clock enable and the async reset.
  logic [7:0]  powerCtl_r;
  logic [7:0]  powerCtl_nxt;
  logic [7:0]  sysCtl_r;
  logic [7:0]  sysCtl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  cspc_pkg::cspc_switch_t switch_r;
  cspc_pkg::cspc_switch_t switch_nxt;
  logic        status_r;
  logic        status_nxt;
  logic        gate_r;
  logic        gate_nxt;

  // Layout-dependent masks.
  // The layout input is static; changing it in use would reinterpret stored bits.
  logic [7:0] wMask;
  logic [7:0] stickyMask;
  logic       vccField;
  assign vccField   = (layoutSel == cspc_pkg::CSPC_LAYOUT_VCC_FIELD); // R14
  assign wMask      = vccField ? `CSPC_WMASK_VCC_FIELD : `CSPC_WMASK_SUPPLY_ENABLE;
  assign stickyMask = vccField ? `CSPC_STICKY_VCC_FIELD : `CSPC_STICKY_SUPPLY_ENABLE;

  // Registers are kept as word indices; the byte address is four times the index.
  // The indices are twelve bits, so the cast only ever pads with zeros.
  // A full compare also refuses byte addresses that are not word aligned.
  localparam logic [ADDR_W-1:0] PWR_ADDR  = ADDR_W'({`CSPC_SOCKET_POWER_CONTROL_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'({`CSPC_SOCKET_STATUS_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] SYS_ADDR  = ADDR_W'({`CSPC_SYSTEM_CONTROL_IDX, 2'h0});

  // APB decode: one-wait answer, pready rises one cycle after the access phase opens.
  logic access;
  logic hitPower;
  logic hitStatus;
  logic hitSys;
  assign access    = psel && penable && !pready_r;
  assign hitPower  = (paddr == PWR_ADDR);
  assign hitStatus = (paddr == STAT_ADDR);
  assign hitSys    = (paddr == SYS_ADDR);

  // Register writes, reset clears and bus answer.
  always_comb
  begin
    powerCtl_nxt = powerCtl_r;
    sysCtl_nxt   = sysCtl_r;
    prdata_nxt   = 32'h0;
    pready_nxt   = 1'b0;
    pslverr_nxt  = 1'b0;
    // A global reset clears everything; a bus reset spares the sticky bits only with events on.
    if (grstSync)
    begin
      powerCtl_nxt = `CSPC_SOCKET_POWER_CONTROL_RESET; // R12
      sysCtl_nxt   = `CSPC_SYSTEM_CONTROL_RESET;
    end
    else if (prstSync)
    begin
      // With events on, the marked bits survive so a wake-up finds the last setting.
      if (pmeEnable)
      begin
        powerCtl_nxt = powerCtl_r & stickyMask; // R12
      end
      else
      begin
        powerCtl_nxt = `CSPC_SOCKET_POWER_CONTROL_RESET; // R12
      end
      sysCtl_nxt = `CSPC_SYSTEM_CONTROL_RESET;
    end
    else if (access)
    begin
      // Only the first access edge is taken; pready_r blocks a second take.
      pready_nxt = 1'b1;
      if (hitPower)
      begin
        // Reserved bits are dropped on write as well as masked on read.
        if (pwrite)
        begin
          powerCtl_nxt = pwdata[7:0] & wMask; // R2 R5 R8 R10
        end
        prdata_nxt = {24'h0, powerCtl_r & wMask}; // R2 R5 R8 R10
      end
      else if (hitSys)
      begin
        // Only the level select bit is held; the rest lies outside this block.
        if (pwrite)
        begin
          sysCtl_nxt = {5'h0, pwdata[`CSPC_LEGACY_LEVEL_BIT], 2'h0};
        end
        prdata_nxt = {24'h0, sysCtl_r};
      end
      else if (hitStatus)
      begin
        // Status reflects the filtered detect pins and the applied supply.
        // Status bits not kept by this block read zero.
        prdata_nxt = {24'h0, 1'b0, status_r, 2'h0, cd2Seated, cd1Seated, 2'h0}; // R13
      end
      else
      begin
        // Unmapped or misaligned addresses answer with an error and change nothing.
        pslverr_nxt = 1'b1;
      end
    end
  end

  // Power switch decode from the programmed setting.
  // It reads registered state only, so the switch command never glitches mid-write.
  cspc_pkg::cspc_vcc_t vccReq;
  logic [1:0]          vppBits;
  logic                legacyLevel;
  logic                cardPresent;
  always_comb
  begin
    // Shorthand for the fields and pins that the decode reads.
    vppBits     = powerCtl_r[`CSPC_VPP_MSB:`CSPC_VPP_LSB];
    legacyLevel = sysCtl_r[`CSPC_LEGACY_LEVEL_BIT];
    cardPresent = cd1Seated && cd2Seated;
    switch_nxt  = switch_r;
    vccReq      = cspc_pkg::CSPC_VCC_OFF;
    // Each layout encodes the Vcc request its own way; both end in one level.
    if (vccField)
    begin
      case (powerCtl_r[`CSPC_VCC_MSB:`CSPC_VCC_LSB])
        2'h2:    vccReq = cspc_pkg::CSPC_VCC_5V; // R9
        2'h3:    vccReq = cspc_pkg::CSPC_VCC_3V3; // R9
        default: vccReq = cspc_pkg::CSPC_VCC_OFF; // R9
      endcase
    end
    else if (powerCtl_r[`CSPC_SUPPLY_ENABLE_BIT])
    begin
      // Level select bit set picks 3.3 V, clear picks 5 V.
      vccReq = legacyLevel ? cspc_pkg::CSPC_VCC_3V3 : cspc_pkg::CSPC_VCC_5V; // R4
    end
    // Auto switching only exists in the supply-enable layout.
    switch_nxt.autoSwitch = !vccField && powerCtl_r[`CSPC_AUTO_SWITCH_BIT]; // R3
    // Auto switching drops supply while no card is seated.
    if (switch_nxt.autoSwitch && !cardPresent)
    begin
      vccReq = cspc_pkg::CSPC_VCC_OFF; // R3
    end
    switch_nxt.vcc = vccReq;
    // Vpp is forced off while Vcc is off, so no request reaches an unpowered socket.
    if (vccReq != cspc_pkg::CSPC_VCC_OFF)
    begin
      case (vppBits)
        2'h2:    switch_nxt.vpp = cspc_pkg::CSPC_VPP_12V; // R6 R11
        2'h1:    switch_nxt.vpp = vccField ? cspc_pkg::CSPC_VPP_OFF : cspc_pkg::CSPC_VPP_VCC; // R6
        default: switch_nxt.vpp = cspc_pkg::CSPC_VPP_OFF; // R6 R11
      endcase
    end
    else
    begin
      switch_nxt.vpp = cspc_pkg::CSPC_VPP_OFF; // R7
    end
    // Both gate copies come from bit 7, so the card side and the switch agree.
    switch_nxt.outputGate = powerCtl_r[`CSPC_OUTPUT_GATE_BIT]; // R1
    gate_nxt   = powerCtl_r[`CSPC_OUTPUT_GATE_BIT]; // R1
    status_nxt = (vccReq != cspc_pkg::CSPC_VCC_OFF); // R13
  end

  // State registers; the clock enable freezes everything.
  // The reset filters freeze too, so a pin reset pulsed while frozen is missed.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      powerCtl_r <= `CSPC_SOCKET_POWER_CONTROL_RESET;
      sysCtl_r   <= `CSPC_SYSTEM_CONTROL_RESET;
      prdata_r   <= 32'h0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      switch_r   <= '0;
      status_r   <= 1'b0;
      gate_r     <= 1'b0;
    end
    else if (clkEn)
    begin
      powerCtl_r <= powerCtl_nxt;
      sysCtl_r   <= sysCtl_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      switch_r   <= switch_nxt;
      status_r   <= status_nxt;
      gate_r     <= gate_nxt;
    end
  end

  // Outputs straight from flip-flops.
  // This costs one cycle of latency from a register write to the switch.
  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign switchCmd           = switch_r;
  assign card_output_gate    = gate_r;
  assign socket_power_status = status_r;

endmodule
`default_nettype wire

//--- common/cspc_defines.svh
// Register offsets, field positions, reset values and per-layout writable and sticky masks for the socket power block.
`ifndef CSPC_DEFINES_SVH
`define CSPC_DEFINES_SVH

// Register word indices; the byte address on APB is four times the index.
`define CSPC_SOCKET_POWER_CONTROL_IDX   12'h802
`define CSPC_SOCKET_STATUS_IDX          12'h800
`define CSPC_SYSTEM_CONTROL_IDX         12'h808

// Reset values of the power control and system control registers.
`define CSPC_SOCKET_POWER_CONTROL_RESET 8'h00
`define CSPC_SYSTEM_CONTROL_RESET       8'h00

// Field positions common to both layouts.
`define CSPC_OUTPUT_GATE_BIT            7
`define CSPC_VPP_LSB                    0
`define CSPC_VPP_MSB                    1

// Supply-enable layout.
`define CSPC_AUTO_SWITCH_BIT            5
`define CSPC_SUPPLY_ENABLE_BIT          4

// Vcc-field layout.
`define CSPC_VCC_LSB                    3
`define CSPC_VCC_MSB                    4

// System control: legacy supply level select bit.
`define CSPC_LEGACY_LEVEL_BIT           2

// Socket status: power status bit.
`define CSPC_POWER_STATUS_BIT           6

// Writable masks per layout; every other bit is reserved and reads zero.
`define CSPC_WMASK_SUPPLY_ENABLE        8'hb3
`define CSPC_WMASK_VCC_FIELD            8'h9b

// Bits cleared only by the global reset while power-management events are on.
`define CSPC_STICKY_SUPPLY_ENABLE       8'h20
`define CSPC_STICKY_VCC_FIELD           8'h9b

`endif

//--- common/cspc_pkg.sv
// Types shared by the socket power control block.
package cspc_pkg;

  // Layout choice made by the static configuration input.
  typedef enum logic
  {
    CSPC_LAYOUT_SUPPLY_ENABLE,
    CSPC_LAYOUT_VCC_FIELD
  } cspc_layout_t;

  // Vcc level applied to the socket.
  typedef enum logic [1:0]
  {
    CSPC_VCC_OFF,
    CSPC_VCC_5V,
    CSPC_VCC_3V3
  } cspc_vcc_t;

  // Vpp level applied to the socket.
  typedef enum logic [1:0]
  {
    CSPC_VPP_OFF,
    CSPC_VPP_12V,
    CSPC_VPP_VCC
  } cspc_vpp_t;

  // Switch command handed to the socket power switch.
  typedef struct packed
  {
    cspc_vcc_t vcc;
    cspc_vpp_t vpp;
    logic      autoSwitch;
    logic      outputGate;
  } cspc_switch_t;

endpackage

//--- design/cspc_sync.sv
// Three-stage synchroniser with agreement filter for one asynchronous input.
`timescale 1ns/1ps
`default_nettype none
module cspc_sync
(
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic clkEn,
  // Asynchronous level in, filtered level out.
  input  wire logic asyncIn,
  output var  logic syncOut
);

  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic       out_r;
  logic       out_nxt;

  // The first stage only feeds the second; a change counts once stages two and three agree.
  always_comb
  begin
    stage_nxt = {stage_r[1:0], asyncIn};
    out_nxt   = (stage_r[1] == stage_r[2]) ? stage_r[2] : out_r;
  end

  // Registers only.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage_r <= 3'h0;
      out_r   <= 1'b0;
    end
    else if (clkEn)
    begin
      stage_r <= stage_nxt;
      out_r   <= out_nxt;
    end
  end

  assign syncOut = out_r;

endmodule
`default_nettype wire

//--- sim/cspc_socket_power_control_reg_monitor.sv
// Assertion checker for the socket power control register ports.
`timescale 1ns/1ps
`default_nettype none
module cspc_socket_power_control_reg_monitor
#(
  parameter int ADDR_W = 14
)
(
  // Clock, resets and layout.
  input wire logic                   sys_clk,
  input wire logic                   nrst,
  input wire logic                   global_reset_in_n,
  input wire logic                   bus_reset_in_n,
  input wire cspc_pkg::cspc_layout_t layoutSel,
  // APB.
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [ADDR_W-1:0]      paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Switch side.
  input wire cspc_pkg::cspc_switch_t switchCmd,
  input wire logic                   card_output_gate,
  input wire logic                   socket_power_status
);
  // One domain, so one clock and one reset serve every property.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic rdPwr;
  logic vccOn;
  // A completed read of the power register, and whether the switch applies Vcc.
  assign rdPwr = pready && !pwrite && paddr == 14'h2008;
  assign vccOn = switchCmd.vcc != cspc_pkg::CSPC_VCC_OFF;
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  ready_wait_a: assert property ($rose(penable) && psel && global_reset_in_n && bus_reset_in_n
    |=> pready) else $error("pready not one cycle after access");
  slverr_map_a: assert property (pready
    |-> pslverr == !(paddr inside {14'h2000, 14'h2008, 14'h2020}))
    else $error("pslverr wrong for address");
  rsv_supply_a: assert property (rdPwr && !layoutSel |-> (prdata & 32'hffffff4c) == 0)
    else $error("reserved bits read nonzero");
  rsv_vcc_a: assert property (rdPwr && layoutSel |-> (prdata & 32'hffffff64) == 0)
    else $error("reserved bits read nonzero");
  gate_write_a: assert property (pready && pwrite && paddr == 14'h2008
    |=> card_output_gate == $past(pwdata[7])) else $error("output gate not written");
  vpp_vcc_off_a: assert property (!vccOn |-> switchCmd.vpp == cspc_pkg::CSPC_VPP_OFF)
    else $error("Vpp applied without Vcc");
  vpp_follow_a: assert property (switchCmd.vpp == cspc_pkg::CSPC_VPP_VCC |-> !layoutSel)
    else $error("Vpp follow code in wrong layout");
  status_vcc_a: assert property (socket_power_status == vccOn)
    else $error("power status disagrees with Vcc");
  // Main traffic kinds.
  cov_write_c: cover property (pready && pwrite && paddr == 14'h2008);
  cov_err_c: cover property (pready && pslverr);
  cov_12v_c: cover property (switchCmd.vpp == cspc_pkg::CSPC_VPP_12V);
endmodule
bind cspc_socket_power_control_reg cspc_socket_power_control_reg_monitor #(.ADDR_W(ADDR_W)) mon_u
  (.sys_clk, .nrst, .global_reset_in_n, .bus_reset_in_n, .layoutSel, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .switchCmd, .card_output_gate,
   .socket_power_status);
`default_nettype wire

//--- sim/cspc_socket_model.sv
// Behavioural socket with power switch and a removable card.
`timescale 1ns/1ps
`default_nettype none
module cspc_socket_model
(
  // From the controller.
  input  wire cspc_pkg::cspc_switch_t switchCmd,
  input  wire logic                   card_output_gate,
  // Card presence set by the bench.
  input  wire logic                   present,
  // Detect pins, pulled up while the socket is empty.
  output logic                        cardDetect1_n,
  output logic                        cardDetect2_n,
  output logic                        cardActive
);
  // Both detect contacts close together; a half-seated card is not modelled.
  assign cardDetect1_n = !present;
  assign cardDetect2_n = !present;
  // The card only runs when powered and its outputs are let through.
  assign cardActive = present && card_output_gate && switchCmd.vcc != cspc_pkg::CSPC_VCC_OFF;
endmodule
`default_nettype wire

//--- sim/cspc_socket_power_control_reg_tb_top.sv
// Self-checking bench for the socket power control register.
`timescale 1ns/1ps
`default_nettype none
`include "cspc_defines.svh"
module cspc_socket_power_control_reg_tb_top;
  logic                   sys_clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   glbN = 1'b1;
  logic                   busN = 1'b1;
  logic                   pme = 1'b0;
  logic                   present = 1'b1;
  logic                   en = 1'b1;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [13:0]            paddr = '0;
  logic [31:0]            pwdata = '0;
  logic [31:0]            prdata;
  logic                   pready, pslverr, cd1N, cd2N, gate, pwrStat, err, act;
  logic [31:0]            rd;
  logic [7:0]             v, m, e;
  logic                   lvl;
  cspc_pkg::cspc_layout_t lay = cspc_pkg::CSPC_LAYOUT_SUPPLY_ENABLE;
  cspc_pkg::cspc_switch_t sw;
  int                     nErrors = 0;
  int                     checkCount = 0;
  // 200 MHz clock.
  always #2.5 sys_clk = ~sys_clk;
  cspc_socket_power_control_reg dut_u (.sys_clk(sys_clk), .nrst(nrst), .clkEn(en),
    .global_reset_in_n(glbN), .bus_reset_in_n(busN), .pmeEnable(pme), .layoutSel(lay),
    .cardDetect1_n(cd1N), .cardDetect2_n(cd2N), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .switchCmd(sw), .card_output_gate(gate), .socket_power_status(pwrStat));
  cspc_socket_model sock_u (.switchCmd(sw), .card_output_gate(gate), .present(present),
    .cardDetect1_n(cd1N), .cardDetect2_n(cd2N), .cardActive(act));
  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) nErrors++;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register read compare under a mask; outputs compare.
  task automatic chkRd(input logic [13:0] a, input logic [31:0] exp, input logic [31:0] mk);
    apb(1'b0, a, 32'h0);
    chk(rd & mk, exp);
  endtask
  task automatic chkOut(input logic [7:0] exp);
    chk({24'h0, gate, pwrStat, sw}, {24'h0, exp});
  endtask
  // Expected {gate, status, vcc, vpp, auto, gate} from register, level bit and card.
  function automatic logic [7:0] expOut(logic l, logic [7:0] r, logic lv, logic card);
    logic [1:0] vcc, vpp;
    logic       au;
    vcc = 2'h0;
    vpp = 2'h0;
    au = !l && r[5];
    if (r[4]) vcc = (l ? r[3] : lv) ? 2'h2 : 2'h1;
    if (au && !card) vcc = 2'h0;
    if (vcc != 2'h0 && r[1:0] == 2'h2) vpp = 2'h1;
    if (vcc != 2'h0 && !l && r[1:0] == 2'h1) vpp = 2'h2;
    return {r[7], vcc != 2'h0, vcc, vpp, au, r[7]};
  endfunction
  // Pulse the global (g=1) or bus reset pin past its filter.
  task automatic pin(input logic g);
    if (g) glbN <= 1'b0;
    else busN <= 1'b0;
    repeat (6) @(posedge sys_clk);
    glbN <= 1'b1;
    busN <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog well beyond the thousand or so cycles the tests take.
  initial
  begin
    #100000;
    nErrors++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'h106f74b7));
    for (int l = 0; l < 2; l++)
    begin
      lay <= cspc_pkg::cspc_layout_t'(l[0]);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      m = l ? `CSPC_WMASK_VCC_FIELD : `CSPC_WMASK_SUPPLY_ENABLE;
      chkRd(14'h2008, 32'h0, 32'hffffffff);
      // Every Vcc and Vpp code, random other bits, level and card presence.
      for (int i = 0; i < 16; i++)
      begin
        v = 8'($urandom());
        v[4:3] = i[3:2];
        v[1:0] = i[1:0];
        lvl = 1'($urandom());
        present <= 1'($urandom());
        apb(1'b1, 14'h2020, {29'h0, lvl, 2'h0});
        apb(1'b1, 14'h2008, {24'($urandom()), v});
        chkRd(14'h2008, {24'h0, v & m}, 32'hffffffff);
        repeat (8) @(posedge sys_clk);
        #1;
        e = expOut(l[0], v & m, lvl, present);
        chkOut(e);
        chk({31'h0, act}, {31'h0, present && e[7] && e[6]});
        chkRd(14'h2000, {25'h0, e[6], 2'h0, present, present, 2'h0}, 32'h4c);
      end
      // Unmapped and misaligned accesses are refused and leave the register alone.
      apb(1'b1, 14'h2030, 32'hff);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 14'h2009, 32'hff);
      chk({31'h0, err}, 32'h1);
      chkRd(14'h2008, {24'h0, v & m}, 32'hffffffff);
      // A low clock enable freezes the reset filter, so a global reset pulse is missed.
      en <= 1'b0;
      pin(1'b1);
      en <= 1'b1;
      chkRd(14'h2008, {24'h0, v & m}, 32'hffffffff);
      // Bus reset keeps sticky bits only while events are enabled.
      apb(1'b1, 14'h2008, 32'hff);
      pme <= 1'b1;
      pin(1'b0);
      chkRd(14'h2008, {24'h0, m & (l ? `CSPC_STICKY_VCC_FIELD : `CSPC_STICKY_SUPPLY_ENABLE)},
        32'hffffffff);
      pin(1'b1);
      chkRd(14'h2008, 32'h0, 32'hffffffff);
      apb(1'b1, 14'h2008, 32'hff);
      pme <= 1'b0;
      pin(1'b0);
      chkRd(14'h2008, 32'h0, 32'hffffffff);
      $display("layout %0d test done", l);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
